// file: hw/hml_monitor.sv
// top of the hart master link error monitor: apb registers, counters, slave table
//
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
`include "hml_defines.svh"
module hml_monitor #(
   parameter int BIT_CYCLES = `HML_BIT_CYC,
   parameter int MS_CYCLES = `HML_MS_CYC,
   parameter int BUF_BYTES = `HML_BUF_BYTES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [3:0] hart_rx,
   input wire logic [3:0] cmd_issue,
   input wire logic [3:0] cmd_retry,
   input wire logic [15:0] cmd_addr,
   input wire logic cycle_done,
   output logic irq
);
   if (MS_CYCLES < 2 || MS_CYCLES > 65535) $error("hml_monitor: bad MS_CYCLES");
   localparam logic [15:0] MSC = 16'(MS_CYCLES - 1);

   // ------------------------------------------------------------
   // per-port receive path
   // ------------------------------------------------------------
   logic [3:0] c_vld, c_perr, c_ferr;
   logic [3:0][7:0] c_data;
   logic [3:0] f_gap, f_ovf, f_message_start_error, f_chk, f_ok;
   logic [3:0][3:0] f_addr;
   hml_pkg::hml_top_t st_reg, st_next;

   for (genvar gp = 0; gp < `HML_NPORTS; gp++) begin : g_port
      hml_char_rx #(
         .BIT_CYCLES(BIT_CYCLES)
      ) u_rx (
         .pclk(pclk),
         .presetn(presetn),
         .rx_pin(hart_rx[gp]),
         .char_vld(c_vld[gp]),
         .char_data(c_data[gp]),
         .par_err(c_perr[gp]),
         .frm_err(c_ferr[gp])
      );
      hml_frame_chk #(
         .BUF_BYTES(BUF_BYTES)
      ) u_frm (
         .pclk(pclk),
         .presetn(presetn),
         .char_vld(c_vld[gp]),
         .char_data(c_data[gp]),
         .char_err(c_perr[gp] | c_ferr[gp]),
         .ms_tick(st_reg.tick),
         .ev_gap(f_gap[gp]),
         .ev_ovf(f_ovf[gp]),
         .ev_message_start_error(f_message_start_error[gp]),
         .ev_chk(f_chk[gp]),
         .ev_ok(f_ok[gp]),
         .slave_addr(f_addr[gp])
      );
   end

   // ------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------
   function automatic logic hml_is_port(input logic [11:0] a);
      return (a[11:8] == `HML_A_PORT) && (a[1:0] == 2'b00);
   endfunction : hml_is_port

   function automatic logic hml_is_rxd(input logic [11:0] a);
      return (a[11:4] == {4'h0, `HML_A_RXD}) && (a[1:0] == 2'b00);
   endfunction : hml_is_rxd

   function automatic logic hml_mapped(input logic [11:0] a);
      logic ok;
      ok = (a == `HML_A_IST) || (a == `HML_A_MSK) || (a == `HML_A_SCAN) || hml_is_rxd(a);
      if (hml_is_port(a)) begin
         ok = (a[5:2] < 4'(`HML_NKIND)) || (a[5:2] == `HML_I_TMO) || (a[5:2] == `HML_I_SLV);
      end
      return ok;
   endfunction : hml_mapped

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   logic access;
   logic [1:0] ap;
   logic [6:0] ev;
   logic tmo;

   always_comb begin
      st_next = st_reg;
      ev = '0;
      tmo = 1'b0;
      ap = paddr[7:6];
      access = psel && penable && st_reg.pready;
      st_next.pready = 1'b0;
      st_next.pslverr = 1'b0;

      // millisecond enable for gap and timeout timing
      if (st_reg.div == 16'h0000) begin
         st_next.div = MSC;
         st_next.tick = 1'b1;
      end else begin
         st_next.div = st_reg.div - 16'h0001;
         st_next.tick = 1'b0;
      end

      if (cycle_done) begin
         st_next.scan = st_reg.scan + 32'h0000_0001;
      end

      // answer one cycle into the access phase
      if (psel && penable && !st_reg.pready) begin
         st_next.pready = 1'b1;
         st_next.pslverr = !hml_mapped(paddr);
         st_next.prdata = 32'h0000_0000;
         if (paddr == `HML_A_IST) begin
            st_next.prdata = {28'h0, st_reg.ist};
         end else if (paddr == `HML_A_MSK) begin
            st_next.prdata = {28'h0, st_reg.msk};
         end else if (paddr == `HML_A_SCAN) begin
            st_next.prdata = st_reg.scan;
         end else if (hml_is_rxd(paddr)) begin
            st_next.prdata = {23'h0, st_reg.rxv[paddr[3:2]], st_reg.rxd[paddr[3:2]]};
         end else if (hml_is_port(paddr)) begin
            if (paddr[5:2] < 4'(`HML_NKIND)) begin
               st_next.prdata = {16'h0, st_reg.cnt[ap][3'(paddr[5:2])]};
            end else if (paddr[5:2] == `HML_I_TMO) begin
               st_next.prdata = {16'h0, st_reg.tmo_cfg[ap]};
            end else if (paddr[5:2] == `HML_I_SLV) begin
               st_next.prdata = 32'(st_reg.slv[ap]);
            end
         end
      end

      // register side effects happen only on the completing edge
      if (access && pwrite) begin
         if (paddr == `HML_A_IST) begin
            st_next.ist = st_reg.ist & ~pwdata[3:0];
         end else if (paddr == `HML_A_MSK) begin
            st_next.msk = pwdata[3:0];
         end else if (hml_is_port(paddr) && paddr[5:2] == `HML_I_TMO) begin
            st_next.tmo_cfg[ap] = pwdata[15:0];
         end
      end
      if (access && !pwrite && hml_is_rxd(paddr)) begin
         st_next.rxv[paddr[3:2]] = 1'b0;
      end

      // events come after the software clears so that a set always wins
      for (int p = 0; p < `HML_NPORTS; p++) begin
         tmo = 1'b0;
         if (cmd_issue[p]) begin
            st_next.pend[p] = 1'b1;
            st_next.tcnt[p] = 16'h0000;
            st_next.tgt[p] = cmd_addr[4*p +: 4];
         end else if (f_ok[p] && st_reg.pend[p]) begin
            st_next.pend[p] = 1'b0;
         end else if (st_reg.tick && st_reg.pend[p]) begin
            st_next.tcnt[p] = st_reg.tcnt[p] + 16'h0001;
            if (st_reg.tcnt[p] + 16'h0001 >= st_reg.tmo_cfg[p]) begin
               tmo = 1'b1;
               st_next.pend[p] = 1'b0;
            end
         end
         if (f_ok[p]) begin
            st_next.slv[p][f_addr[p]] = hml_pkg::HML_SL_OK;
         end
         if (f_chk[p]) begin
            st_next.slv[p][f_addr[p]] = hml_pkg::HML_SL_ERR;
         end
         if (tmo) begin
            st_next.slv[p][st_reg.tgt[p]] = hml_pkg::HML_SL_ERR;
         end

         ev[`HML_K_GAP] = f_gap[p];
         ev[`HML_K_OVF] = f_ovf[p];
         ev[`HML_K_MESSAGE_START_ERROR] = f_message_start_error[p];
         ev[`HML_K_RTY] = cmd_retry[p];
         ev[`HML_K_CHK] = f_chk[p];
         // overrun: a new byte lands while the last one is still unread
         // error flags stand until the next character, so only the strobe counts them
         ev[`HML_K_OPF] = c_vld[p] & (c_perr[p] | c_ferr[p] | st_reg.rxv[p]);
         ev[`HML_K_TMO] = tmo;
         if (c_vld[p]) begin
            st_next.rxd[p] = c_data[p];
            st_next.rxv[p] = 1'b1;
         end
         for (int k = 0; k < `HML_NKIND; k++) begin
            if (ev[k]) begin
               st_next.cnt[p][k] = st_reg.cnt[p][k] + 16'h0001;
            end
         end
         if (ev != 7'h00) begin
            st_next.ist[p] = 1'b1;
         end
      end
      st_next.irq = |(st_next.ist & st_next.msk);
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= '0;
         st_reg.tmo_cfg <= {4{`HML_TMO_RST}};
      end else begin
         st_reg <= st_next;
      end
   end

   assign prdata = st_reg.prdata;
   assign pready = st_reg.pready;
   assign pslverr = st_reg.pslverr;
   assign irq = st_reg.irq;
endmodule : hml_monitor

// file: hw/hml_defines.svh
// constants of the hart master link error monitor
// How it works
// - count gaps over 20 ms inside a message
// - count messages longer than receive buffer
// - count messages with under 3 ff preambles
// - count each command retry
// - count check byte mismatches
// - count byte lost before being read
// - even parity failure counts as error
// - zero stop bit counts as error
// - count replies missing past configured timeout
// - per-slave status: error, ok, not polled
// - four ports, each read separately
// - count finished program cycles
`ifndef HML_DEFINES_SVH
`define HML_DEFINES_SVH
`define HML_CLK_HZ 50000000
`define HML_BAUD 1200
`define HML_BIT_CYC (`HML_CLK_HZ / `HML_BAUD)
`define HML_MS_PER_S 1000
`define HML_MS_CYC (`HML_CLK_HZ / `HML_MS_PER_S)
`define HML_GAP_MS 5'd20
`define HML_MIN_PRE 2'd3
`define HML_PREAMBLE 8'hff
`define HML_BUF_BYTES 32
`define HML_LONG_ADDR 3'd5
`define HML_SHORT_ADDR 3'd1
`define HML_TMO_RST 16'h01f4
`define HML_NPORTS 4
`define HML_NKIND 7
`define HML_K_GAP 0
`define HML_K_OVF 1
`define HML_K_MESSAGE_START_ERROR 2
`define HML_K_RTY 3
`define HML_K_CHK 4
`define HML_K_OPF 5
`define HML_K_TMO 6
`define HML_A_IST 12'h000
`define HML_A_MSK 12'h004
`define HML_A_SCAN 12'h008
`define HML_A_RXD 4'h1
`define HML_A_PORT 4'h1
`define HML_I_TMO 4'h8
`define HML_I_SLV 4'h9
`endif

// file: hw/hml_pkg.sv
// types of the hart master link error monitor
package hml_pkg;
   typedef enum logic [1:0] {HML_SL_NONE, HML_SL_OK, HML_SL_ERR} hml_slave_t;
   typedef enum logic [2:0] {HML_RX_IDLE, HML_RX_START, HML_RX_DATA, HML_RX_PAR,
      HML_RX_STOP} hml_rx_st_t;
   typedef enum logic [2:0] {HML_F_PRE, HML_F_ADDR, HML_F_CMD, HML_F_BCNT, HML_F_DATA,
      HML_F_CHK} hml_frm_st_t;
   typedef struct packed {
      logic s1, s2;
      hml_rx_st_t st;
      logic [15:0] cnt;
      logic [2:0] bitn;
      logic [7:0] sh;
      logic par, vld, perr, ferr;
   } hml_rx_t;
   typedef struct packed {
      hml_frm_st_t st;
      logic [1:0] pre;
      logic [2:0] left;
      logic [3:0] addr;
      logic [7:0] len, sum;
      logic [4:0] gap;
      logic ev_gap, ev_ovf, ev_message_start_error, ev_chk, ev_ok;
   } hml_frm_t;
   typedef struct packed {
      logic [15:0] div;
      logic tick;
      logic [31:0] scan;
      logic [3:0][6:0][15:0] cnt;
      logic [3:0][15:0] tmo_cfg, tcnt;
      logic [3:0] pend;
      logic [3:0][3:0] tgt;
      hml_slave_t [3:0][15:0] slv;
      logic [3:0][7:0] rxd;
      logic [3:0] rxv, ist, msk;
      logic [31:0] prdata;
      logic pready, pslverr, irq;
   } hml_top_t;
endpackage : hml_pkg

// file: hw/hml_char_rx.sv
// serial character receiver: 8 data bits, even parity, one stop bit
`timescale 1ns/10ps
`include "hml_defines.svh"
module hml_char_rx #(
   parameter int BIT_CYCLES = `HML_BIT_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic rx_pin,
   output logic char_vld,
   output logic [7:0] char_data,
   output logic par_err,
   output logic frm_err
);
   if (BIT_CYCLES < 4 || BIT_CYCLES > 65535) $error("hml_char_rx: bad BIT_CYCLES");
   localparam logic [15:0] BITC = 16'(BIT_CYCLES - 1);
   localparam logic [15:0] HALFC = 16'(BIT_CYCLES / 2 - 1);
   hml_pkg::hml_rx_t st_reg, st_next;

   always_comb begin
      st_next = st_reg;
      st_next.s1 = rx_pin;
      st_next.s2 = st_reg.s1;
      st_next.vld = 1'b0;
      if (st_reg.cnt != 16'h0000) begin
         st_next.cnt = st_reg.cnt - 16'h0001;
      end
      case (st_reg.st)
         hml_pkg::HML_RX_IDLE: begin
            if (!st_reg.s2) begin
               st_next.st = hml_pkg::HML_RX_START;
               st_next.cnt = HALFC;
            end
         end
         hml_pkg::HML_RX_START: begin
            if (st_reg.cnt == 16'h0000) begin
               // a glitch shorter than half a bit is not a start bit
               st_next.st = st_reg.s2 ? hml_pkg::HML_RX_IDLE : hml_pkg::HML_RX_DATA;
               st_next.cnt = BITC;
               st_next.bitn = 3'h0;
               st_next.par = 1'b0;
            end
         end
         hml_pkg::HML_RX_DATA: begin
            if (st_reg.cnt == 16'h0000) begin
               st_next.sh = {st_reg.s2, st_reg.sh[7:1]};
               st_next.par = st_reg.par ^ st_reg.s2;
               st_next.bitn = st_reg.bitn + 3'h1;
               st_next.cnt = BITC;
               if (st_reg.bitn == 3'h7) begin
                  st_next.st = hml_pkg::HML_RX_PAR;
               end
            end
         end
         hml_pkg::HML_RX_PAR: begin
            if (st_reg.cnt == 16'h0000) begin
               st_next.perr = st_reg.par ^ st_reg.s2;
               st_next.cnt = BITC;
               st_next.st = hml_pkg::HML_RX_STOP;
            end
         end
         hml_pkg::HML_RX_STOP: begin
            if (st_reg.cnt == 16'h0000) begin
               st_next.ferr = !st_reg.s2;
               st_next.vld = 1'b1;
               st_next.st = hml_pkg::HML_RX_IDLE;
            end
         end
         default: st_next.st = hml_pkg::HML_RX_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= '0;
         st_reg.s1 <= 1'b1;
         st_reg.s2 <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   assign char_vld = st_reg.vld;
   assign char_data = st_reg.sh;
   assign par_err = st_reg.perr;
   assign frm_err = st_reg.ferr;
endmodule : hml_char_rx

// file: hw/hml_frame_chk.sv
// message checker: preambles, length, check byte and gaps of one port
`timescale 1ns/10ps
`include "hml_defines.svh"
module hml_frame_chk #(
   parameter int BUF_BYTES = `HML_BUF_BYTES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic char_vld,
   input wire logic [7:0] char_data,
   input wire logic char_err,
   input wire logic ms_tick,
   output logic ev_gap,
   output logic ev_ovf,
   output logic ev_message_start_error,
   output logic ev_chk,
   output logic ev_ok,
   output logic [3:0] slave_addr
);
   if (BUF_BYTES < 1 || BUF_BYTES > 255) $error("hml_frame_chk: bad BUF_BYTES");
   localparam logic [7:0] BUFB = 8'(BUF_BYTES);
   hml_pkg::hml_frm_t st_reg, st_next;
   logic active;

   always_comb begin
      st_next = st_reg;
      {st_next.ev_gap, st_next.ev_ovf, st_next.ev_message_start_error} = '0;
      {st_next.ev_chk, st_next.ev_ok} = '0;
      active = (st_reg.st != hml_pkg::HML_F_PRE) || (st_reg.pre != 2'd0);
      if (char_vld) begin
         st_next.gap = 5'd0;
         st_next.sum = st_reg.sum ^ char_data;
         case (st_reg.st)
            hml_pkg::HML_F_PRE: begin
               if (char_data == `HML_PREAMBLE) begin
                  if (st_reg.pre != `HML_MIN_PRE) begin
                     st_next.pre = st_reg.pre + 2'd1;
                  end
               end else begin
                  st_next.ev_message_start_error = (st_reg.pre < `HML_MIN_PRE);
                  st_next.sum = char_data;
                  st_next.left = char_data[7] ? `HML_LONG_ADDR : `HML_SHORT_ADDR;
                  st_next.st = hml_pkg::HML_F_ADDR;
               end
            end
            hml_pkg::HML_F_ADDR: begin
               st_next.addr = char_data[3:0];
               st_next.left = st_reg.left - 3'd1;
               if (st_reg.left == 3'd1) begin
                  st_next.st = hml_pkg::HML_F_CMD;
               end
            end
            hml_pkg::HML_F_CMD: st_next.st = hml_pkg::HML_F_BCNT;
            hml_pkg::HML_F_BCNT: begin
               st_next.len = char_data;
               st_next.ev_ovf = (char_data > BUFB);
               st_next.st = (char_data == 8'h00) ? hml_pkg::HML_F_CHK : hml_pkg::HML_F_DATA;
            end
            hml_pkg::HML_F_DATA: begin
               st_next.len = st_reg.len - 8'h01;
               if (st_reg.len == 8'h01) begin
                  st_next.st = hml_pkg::HML_F_CHK;
               end
            end
            hml_pkg::HML_F_CHK: begin
               st_next.ev_chk = (st_reg.sum != char_data);
               st_next.ev_ok = (st_reg.sum == char_data);
               st_next.st = hml_pkg::HML_F_PRE;
               st_next.pre = 2'd0;
            end
            default: st_next.st = hml_pkg::HML_F_PRE;
         endcase
         // a damaged character spoils the message; start over
         if (char_err) begin
            st_next.st = hml_pkg::HML_F_PRE;
            st_next.pre = 2'd0;
            st_next.ev_chk = 1'b0;
            st_next.ev_ok = 1'b0;
         end
      end else if (ms_tick && active) begin
         st_next.gap = st_reg.gap + 5'd1;
         if (st_reg.gap == `HML_GAP_MS) begin
            st_next.ev_gap = 1'b1;
            st_next.st = hml_pkg::HML_F_PRE;
            st_next.pre = 2'd0;
            st_next.gap = 5'd0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign ev_gap = st_reg.ev_gap;
   assign ev_ovf = st_reg.ev_ovf;
   assign ev_message_start_error = st_reg.ev_message_start_error;
   assign ev_chk = st_reg.ev_chk;
   assign ev_ok = st_reg.ev_ok;
   assign slave_addr = st_reg.addr;
endmodule : hml_frame_chk

// file: tb/hml_monitor_checker.sv
// port checker of the hart master link error monitor
`timescale 1ns/10ps
module hml_monitor_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [3:0] hart_rx,
   input wire logic [3:0] cmd_issue,
   input wire logic [3:0] cmd_retry,
   input wire logic [15:0] cmd_addr,
   input wire logic cycle_done,
   input wire logic irq
);
   logic [3:0] msk_reg;
   logic [31:0] scan_reg;
   // shadow of mask and cycle count, seen only through the ports
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         msk_reg <= 4'h0;
         scan_reg <= 32'h0;
      end else begin
         if (psel && penable && pready && pwrite && paddr == 12'h004) begin
            msk_reg <= pwdata[3:0];
         end
         if (cycle_done) begin
            scan_reg <= scan_reg + 32'h1;
         end
      end
   end
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_ready_one_wait: assert property (psel && penable && !pready |=> pready)
      else $error("pready late");
   chk_ready_single: assert property (pready |=> !pready)
      else $error("pready held");
   chk_setup_quiet: assert property (psel && !penable |-> !pready)
      else $error("pready in setup");
   chk_error_with_ready: assert property (pslverr |-> pready && psel && penable)
      else $error("stray pslverr");
   chk_error_zero_data: assert property (pslverr |-> prdata == 32'h0)
      else $error("data on error");
   chk_scan_mapped: assert property (pready && paddr == 12'h008 |-> !pslverr)
      else $error("scan refused");
   chk_scan_count: assert property (pready && !pwrite && paddr == 12'h008
      |-> prdata == scan_reg || prdata == scan_reg - 32'h1) else $error("scan count");
   chk_irq_masked: assert property (msk_reg == 4'h0 && $past(msk_reg) == 4'h0 |-> !irq)
      else $error("irq while masked");
   chk_reset_quiet: assert property ($rose(presetn) |-> !irq && !pready && prdata == 0)
      else $error("outputs after reset");
endmodule : hml_monitor_checker
bind hml_monitor hml_monitor_checker hml_monitor_checker_i (.pclk(pclk), .presetn(presetn),
   .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .hart_rx(hart_rx),
   .cmd_issue(cmd_issue), .cmd_retry(cmd_retry), .cmd_addr(cmd_addr),
   .cycle_done(cycle_done), .irq(irq));

// file: tb/hml_slave_model.sv
// field slave model driving the four serial receive lines
`timescale 1ns/10ps
module hml_slave_model #(
   parameter int BIT_CYCLES = 16
) (
   input wire logic pclk,
   output logic [3:0] line
);
   initial begin
      line = 4'hf;
   end
   task automatic bit_out(input int p, input logic v, input int len);
      @(posedge pclk);
      line[p] <= v;
      repeat (len - 1) @(posedge pclk);
   endtask : bit_out
   task automatic send_char(input int p, input logic [7:0] b, input logic bp, input logic bs);
      int i;
      bit_out(p, 1'b0, BIT_CYCLES);
      for (i = 0; i < 8; i++) begin
         bit_out(p, b[i], BIT_CYCLES);
      end
      bit_out(p, (^b) ^ bp, BIT_CYCLES);
      // a bad stop is held only past mid-bit so no phantom start follows
      bit_out(p, !bs, bs ? BIT_CYCLES * 3 / 4 : BIT_CYCLES);
      bit_out(p, 1'b1, 2);
   endtask : send_char
endmodule : hml_slave_model

// file: tb/hml_monitor_test.sv
// self-checking bench of the hart master link error monitor
`timescale 1ns/10ps
module hml_monitor_test;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, cycle_done, rd_err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd_val;
   logic [3:0] hart_rx, cmd_issue, cmd_retry;
   logic [15:0] cmd_addr;
   int err_count, tests_run, cyc;
   hml_slave_model #(.BIT_CYCLES(16)) hml_slave_model_i (.pclk(pclk), .line(hart_rx));
   hml_monitor #(.BIT_CYCLES(16), .MS_CYCLES(20), .BUF_BYTES(4)) hml_monitor_i (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .hart_rx(hart_rx), .cmd_issue(cmd_issue), .cmd_retry(cmd_retry), .cmd_addr(cmd_addr),
      .cycle_done(cycle_done), .irq(irq));
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   // ------------------------------------------------------------
   // bus and compare helpers
   // ------------------------------------------------------------
   task end_sim;
      $display("checks %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : end_sim
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         err_count++;
         $display("wrong value at %0t: run hung", $time);
         end_sim();
      end
   end
   task check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: addr %h got %h want %h", $time, paddr, got, exp);
      end
   endtask : check
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd_val = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(rd_val, exp);
   endtask : rd
   function automatic logic [11:0] ca(input int p, input int k);
      return 12'h100 + 12'(64 * p + 4 * k);
   endfunction : ca
   // reading the byte after each character keeps overrun out of normal traffic
   task sc(input int p, input logic [7:0] b, input logic bp, input logic bs, input logic rdb);
      hml_slave_model_i.send_char(p, b, bp, bs);
      repeat (4) @(posedge pclk);
      if (rdb) begin
         apb(1'b0, 12'h010 + 12'(4 * p), 32'h0);
         if (!bp && !bs) check(rd_val, {23'h0, 1'b1, b});
      end
   endtask : sc
   task frame(input int p, input int npre, input logic [7:0] n, input logic bad);
      int i;
      for (i = 0; i < npre; i++) sc(p, 8'hff, 1'b0, 1'b0, 1'b1);
      sc(p, 8'h02, 1'b0, 1'b0, 1'b1);
      sc(p, 8'h80, 1'b0, 1'b0, 1'b1);
      sc(p, 8'h01, 1'b0, 1'b0, 1'b1);
      sc(p, n, 1'b0, 1'b0, 1'b1);
      for (i = 0; i < n; i++) sc(p, 8'h00, 1'b0, 1'b0, 1'b1);
      sc(p, 8'h83 ^ n ^ {7'h0, bad}, 1'b0, 1'b0, 1'b1);
      repeat (10) @(posedge pclk);
   endtask : frame
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task t_reset;
      int p, k;
      for (p = 0; p < 4; p++) begin
         for (k = 0; k < 7; k++) rd(ca(p, k), 32'h0);
         rd(ca(p, 8), 32'h1f4);
         rd(ca(p, 9), 32'h0);
      end
      rd(12'hffc, 32'h0);
      check({31'h0, rd_err}, 32'h1);
   endtask : t_reset
   task t_frames;
      frame(1, 3, 8'h00, 1'b0);
      rd(ca(1, 9), 32'h1);
      rd(ca(1, 2), 32'h0);
      rd(ca(1, 5), 32'h0);
      frame(0, 3, 8'h00, 1'b1);
      rd(ca(0, 4), 32'h1);
      rd(ca(0, 9), 32'h2);
      frame(2, 2, 8'h00, 1'b0);
      rd(ca(2, 2), 32'h1);
      frame(3, 3, 8'h04, 1'b0);
      rd(ca(3, 1), 32'h0);
      frame(3, 3, 8'h05, 1'b0);
      rd(ca(3, 1), 32'h1);
   endtask : t_frames
   task t_char_err;
      sc(0, 8'h55, 1'b0, 1'b0, 1'b0);
      sc(0, 8'h55, 1'b0, 1'b0, 1'b1);
      rd(ca(0, 5), 32'h1);
      sc(1, 8'h55, 1'b1, 1'b0, 1'b1);
      sc(1, 8'h55, 1'b0, 1'b1, 1'b1);
      rd(ca(1, 5), 32'h2);
   endtask : t_char_err
   task t_gap;
      sc(2, 8'hff, 1'b0, 1'b0, 1'b1);
      // about 14 ms between the two characters: well under the gap limit
      repeat (100) @(posedge pclk);
      sc(2, 8'hff, 1'b0, 1'b0, 1'b1);
      rd(ca(2, 0), 32'h0);
      repeat (600) @(posedge pclk);
      rd(ca(2, 0), 32'h1);
   endtask : t_gap
   task t_timeout;
      apb(1'b1, ca(3, 8), 32'h3);
      rd(ca(3, 8), 32'h3);
      cmd_issue <= 4'h8;
      cmd_retry <= 4'h8;
      cmd_addr <= 16'h5000;
      @(posedge pclk);
      cmd_issue <= 4'h0;
      cmd_retry <= 4'h0;
      rd(ca(3, 6), 32'h0);
      repeat (100) @(posedge pclk);
      rd(ca(3, 6), 32'h1);
      rd(ca(3, 9), 32'h801);
      rd(ca(3, 3), 32'h1);
   endtask : t_timeout
   task t_scan_irq;
      repeat (3) begin
         cycle_done <= 1'b1;
         @(posedge pclk);
         cycle_done <= 1'b0;
         @(posedge pclk);
      end
      apb(1'b1, 12'h008, 32'hffff);
      rd(12'h008, 32'h3);
      rd(12'h000, 32'hf);
      check({31'h0, irq}, 32'h0);
      apb(1'b1, 12'h004, 32'h1);
      repeat (2) @(posedge pclk);
      check({31'h0, irq}, 32'h1);
      apb(1'b1, 12'h000, 32'hf);
      repeat (2) @(posedge pclk);
      check({31'h0, irq}, 32'h0);
      rd(12'h000, 32'h0);
   endtask : t_scan_irq
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
      cmd_issue = 4'h0;
      cmd_retry = 4'h0;
      cmd_addr = 16'h0;
      cycle_done = 1'b0;
      presetn = 1'b0;
      err_count = 0;
      tests_run = 0;
      cyc = 0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_frames();
      t_char_err();
      t_gap();
      t_timeout();
      t_scan_irq();
      end_sim();
   end
endmodule : hml_monitor_test
